// ### rtl/dib_params.svh
// Timing constants and a reset code for the differential bus bridge.
// Assumes the includer runs on a 50 MHz core clock.
`ifndef DIB_PARAMS_SVH
`define DIB_PARAMS_SVH
`define DIB_CLK_HZ        50000000
`define DIB_SETTLE_US     1000
`define DIB_ARM_US        10000
`define DIB_IDLE_US       100
`define DIB_SETTLE_CYC    ((`DIB_CLK_HZ / 1000000) * `DIB_SETTLE_US)
`define DIB_ARM_CYC       ((`DIB_CLK_HZ / 1000000) * `DIB_ARM_US)
`define DIB_IDLE_CYC      ((`DIB_CLK_HZ / 1000000) * `DIB_IDLE_US)
`define DIB_SYNC_RESET    2'h0
`endif

// ### rtl/dib_pkg.sv
// Types shared by the differential bus bridge.
// Assumes nothing beyond a SystemVerilog compiler.
package dib_pkg;
	typedef enum logic [2:0] {
		DIB_OFF,
		DIB_SETTLE,
		DIB_TERM_WAIT,
		DIB_ARM_WAIT,
		DIB_ARMED,
		DIB_CONNECTED
	} dib_seq_t;
	typedef enum logic [1:0] {
		DIB_DIR_IDLE,
		DIB_DIR_TO_LINE,
		DIB_DIR_TO_CARD
	} dib_dir_t;
endpackage

// ### rtl/dib_channel.sv
// One bridged channel: card open-drain wire to line differential pair.
// Assumes synchronised inputs and a connect level from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module dib_channel
	import dib_pkg::*;
(
	input  wire logic core_clk,      // Core clock
	input  wire logic resetn,        // Sync reset, active low
	input  wire logic connect,       // Sides joined
	input  wire logic card_in,       // Synced card wire level
	input  wire logic line_plus_in,  // Synced plus comparator
	input  wire logic line_minus_in, // Synced minus comparator
	output logic      card_oe,       // Pull card wire low
	output logic      line_plus_oe,  // Pull plus low
	output logic      line_minus_oe, // Drive minus high
	output logic      line_minus_o,  // Minus drive level
	output logic      line_level     // Decoded line level
);
	dib_dir_t   dir_reg;
	dib_dir_t   dir_next;
	logic       line_hi;
	logic [1:0] blank_reg;
	logic [1:0] blank_next;

	// Level from the pair difference only; plus above minus is released
	assign line_hi = line_plus_in & ~line_minus_in;
	assign line_level = line_hi;

	// Direction chosen from whichever side first pulls low; after a release
	// the own drive still echoes through the synchronisers for two edges,
	// so new decisions are blanked then to avoid latching up
	always_comb begin
		dir_next = dir_reg;
		blank_next = (blank_reg != 2'h0) ? blank_reg - 2'h1 : 2'h0;
		if (!connect) begin
			dir_next = DIB_DIR_IDLE;
		end else begin
			case (dir_reg)
				DIB_DIR_IDLE: begin
					if (blank_reg != 2'h0)
						dir_next = DIB_DIR_IDLE;
					else if (!card_in)
						dir_next = DIB_DIR_TO_LINE;
					else if (!line_hi)
						dir_next = DIB_DIR_TO_CARD;
				end
				DIB_DIR_TO_LINE: begin
					if (card_in) begin
						dir_next = DIB_DIR_IDLE;
						blank_next = 2'h2;
					end
				end
				DIB_DIR_TO_CARD: begin
					if (line_hi) begin
						dir_next = DIB_DIR_IDLE;
						blank_next = 2'h2;
					end
				end
				default: dir_next = DIB_DIR_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			dir_reg   <= DIB_DIR_IDLE;
			blank_reg <= 2'h0;
		end else begin
			dir_reg   <= dir_next;
			blank_reg <= blank_next;
		end
	end

	// Transmitter or receiver, never both at once
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			card_oe       <= 1'b0;
			line_plus_oe  <= 1'b0;
			line_minus_oe <= 1'b0;
			line_minus_o  <= 1'b0;
		end else begin
			card_oe       <= (dir_next == DIB_DIR_TO_CARD);
			line_plus_oe  <= (dir_next == DIB_DIR_TO_LINE);
			line_minus_oe <= (dir_next == DIB_DIR_TO_LINE);
			line_minus_o  <= (dir_next == DIB_DIR_TO_LINE);
		end
	end
endmodule // dib_channel
`default_nettype wire

// ### rtl/dib_bridge.sv
// Hot-swap sequencer and two-channel card-to-line bridge.
// Assumes analog comparators present line levels and supply/termination
// status as digital levels; all pins are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "dib_params.svh"
module dib_bridge
	import dib_pkg::*;
#(
	parameter int SETTLE_CYC = `DIB_SETTLE_CYC,
	parameter int ARM_CYC    = `DIB_ARM_CYC,
	parameter int IDLE_CYC   = `DIB_IDLE_CYC
) (
	input  wire logic core_clk,                // Core clock, 50 MHz
	input  wire logic resetn,                  // Sync reset, active low
	input  wire logic enable_in,               // Enable pin, pulled high
	input  wire logic card_side_supply_ok,     // Card supply stable
	input  wire logic line_side_supply_ok,     // Line supply stable
	input  wire logic term_valid,              // Termination thresholds met
	input  wire logic card_clock_in,           // Card clock wire level
	input  wire logic card_data_in,            // Card data wire level
	input  wire logic line_clock_plus_in,      // Clock plus comparator
	input  wire logic line_clock_minus_in,     // Clock minus comparator
	input  wire logic line_data_plus_in,       // Data plus comparator
	input  wire logic line_data_minus_in,      // Data minus comparator
	output logic      card_clock_oe,           // Pull card clock low
	output logic      card_data_oe,            // Pull card data low
	output logic      line_clock_plus_oe,      // Pull clock plus low
	output logic      line_clock_minus_oe,     // Drive clock minus
	output logic      line_clock_minus_o,      // Clock minus level
	output logic      line_data_plus_oe,       // Pull data plus low
	output logic      line_data_minus_oe,      // Drive data minus
	output logic      line_data_minus_o,       // Data minus level
	output logic      insertion_detect_output, // Armed, line examined
	output logic      connected                // Sides joined
);
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic en_s, sup_s, term_s, cclk_s, cdat_s;
	logic lcp_s, lcm_s, ldp_s, ldm_s;
	logic clk_lvl, dat_lvl;
	dib_seq_t seq_reg, seq_next;
	logic [31:0] tmr_reg, tmr_next;
	logic [31:0] idle_reg, idle_next;
	logic dat_prev_reg, stop_seen_reg, stop_seen_next;
	logic conn;

	// Two-flop synchronisers on every pin-derived input
	assign raw = {enable_in, card_side_supply_ok & line_side_supply_ok, term_valid,
		card_clock_in, card_data_in, line_clock_plus_in, line_clock_minus_in,
		line_data_plus_in, line_data_minus_in};
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
		end
	end
	assign {en_s, sup_s, term_s, cclk_s, cdat_s, lcp_s, lcm_s, ldp_s, ldm_s} = s2_reg;

	// Enable is active high; the pad pull-up makes undriven read high
	logic en_on;
	assign en_on = en_s;

	// Idle time counts while both plus wires stay high; STOP is data
	// rising on the pair while clock is high
	always_comb begin
		idle_next = idle_reg;
		stop_seen_next = stop_seen_reg;
		if (seq_reg != DIB_ARMED) begin
			idle_next = '0;
			stop_seen_next = 1'b0;
		end else begin
			if (ldp_s && lcp_s) begin
				if (idle_reg < IDLE_CYC)
					idle_next = idle_reg + 32'h1;
			end else begin
				idle_next = '0;
			end
			if (clk_lvl && dat_lvl && !dat_prev_reg)
				stop_seen_next = 1'b1;
			else if (clk_lvl && !dat_lvl && dat_prev_reg)
				stop_seen_next = 1'b0;
		end
	end

	// Sequencer: settle, termination, arm, wait for enable and idle/STOP
	always_comb begin
		seq_next = seq_reg;
		tmr_next = tmr_reg;
		case (seq_reg)
			DIB_OFF: begin
				tmr_next = '0;
				if (sup_s)
					seq_next = DIB_SETTLE;
			end
			DIB_SETTLE: begin
				tmr_next = tmr_reg + 32'h1;
				if (tmr_reg >= SETTLE_CYC - 1) begin
					seq_next = DIB_TERM_WAIT;
					tmr_next = '0;
				end
			end
			DIB_TERM_WAIT: begin
				if (term_s)
					seq_next = DIB_ARM_WAIT;
			end
			DIB_ARM_WAIT: begin
				tmr_next = tmr_reg + 32'h1;
				if (tmr_reg >= ARM_CYC - 1) begin
					seq_next = DIB_ARMED;
					tmr_next = '0;
				end
			end
			DIB_ARMED: begin
				if (en_on && ((idle_reg >= IDLE_CYC) || (cclk_s && cdat_s && stop_seen_reg)))
					seq_next = DIB_CONNECTED;
			end
			DIB_CONNECTED: begin
				if (!en_on)
					seq_next = DIB_ARMED;
			end
			default: seq_next = DIB_OFF;
		endcase
		if (!sup_s || (seq_reg >= DIB_ARM_WAIT && !term_s)) begin
			seq_next = DIB_OFF;
			tmr_next = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			seq_reg       <= DIB_OFF;
			tmr_reg       <= '0;
			idle_reg      <= '0;
			stop_seen_reg <= 1'b0;
			dat_prev_reg  <= 1'b1;
		end else begin
			seq_reg       <= seq_next;
			tmr_reg       <= tmr_next;
			idle_reg      <= idle_next;
			stop_seen_reg <= stop_seen_next;
			dat_prev_reg  <= dat_lvl;
		end
	end

	// Outputs released everywhere until connected
	assign conn = (seq_reg == DIB_CONNECTED) && en_on;
	assign connected = (seq_reg == DIB_CONNECTED);
	assign insertion_detect_output = (seq_reg == DIB_ARMED) || (seq_reg == DIB_CONNECTED);

	// Clock channel
	dib_channel u_clock (
		.core_clk      (core_clk),
		.resetn        (resetn),
		.connect       (conn),
		.card_in       (cclk_s),
		.line_plus_in  (lcp_s),
		.line_minus_in (lcm_s),
		.card_oe       (card_clock_oe),
		.line_plus_oe  (line_clock_plus_oe),
		.line_minus_oe (line_clock_minus_oe),
		.line_minus_o  (line_clock_minus_o),
		.line_level    (clk_lvl)
	);

	// Data channel
	dib_channel u_data (
		.core_clk      (core_clk),
		.resetn        (resetn),
		.connect       (conn),
		.card_in       (cdat_s),
		.line_plus_in  (ldp_s),
		.line_minus_in (ldm_s),
		.card_oe       (card_data_oe),
		.line_plus_oe  (line_data_plus_oe),
		.line_minus_oe (line_data_minus_oe),
		.line_minus_o  (line_data_minus_o),
		.line_level    (dat_lvl)
	);
endmodule // dib_bridge
`default_nettype wire

// ### tb/dib_props.sv
// Checker for the bridge: hot-swap sequence and channel drive
// Assumes one core clock domain; bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module dib_props (
	input wire logic core_clk, resetn, enable_in, card_side_supply_ok, term_valid,
	input wire logic card_clock_in, card_data_in, line_clock_plus_in, line_data_plus_in,
	input wire logic line_data_minus_in, card_clock_oe, card_data_oe, line_clock_plus_oe,
	input wire logic line_clock_minus_oe, line_data_plus_oe, line_data_minus_oe,
	input wire logic line_data_minus_o, insertion_detect_output, connected
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic any_oe;
	// Any pin drive at all
	assign any_oe = card_clock_oe | card_data_oe | line_clock_plus_oe | line_clock_minus_oe
		| line_data_plus_oe | line_data_minus_oe;
	// Peer reverses the data pair while the card wire is free
	sequence line_rev;
		$fell(line_data_plus_in) && line_data_minus_in && card_data_in && connected && !line_data_plus_oe
			&& term_valid;
	endsequence
	// Card device pulls the clock wire first
	sequence card_low;
		$fell(card_clock_in) && connected && !card_clock_oe && line_clock_plus_in;
	endsequence
	a_apart_no_drive: assert property (!connected && !$past(connected) |-> !any_oe) else $error("drive while apart");
	a_enable_gate: assert property (!enable_in [*5] |-> !connected) else $error("joined with enable low");
	a_armed_first: assert property ($rose(connected) |-> $past(insertion_detect_output)) else $error("joined unarmed");
	a_supply_loss: assert property (!card_side_supply_ok [*5] |-> !insertion_detect_output) else $error("armed unpowered");
	a_term_loss: assert property (!term_valid [*5] |-> !insertion_detect_output) else $error("armed unterminated");
	a_one_way: assert property (!(card_data_oe && line_data_plus_oe) && !(card_clock_oe && line_clock_plus_oe))
		else $error("both directions");
	a_line_to_card: assert property (line_rev |-> ##[1:4] card_data_oe) else $error("reversal not passed");
	a_card_to_line: assert property (card_low |-> ##[1:4] line_clock_plus_oe) else $error("card low not passed");
	a_pair_reverse: assert property ($rose(line_data_plus_oe) |->
		line_data_minus_oe && line_data_minus_o && !$past(card_data_in, 3))
		else $error("pair not reversed");
endmodule // dib_props
bind dib_bridge dib_props u_props (.core_clk, .resetn, .enable_in, .card_side_supply_ok, .term_valid, .card_clock_in,
	.card_data_in, .line_clock_plus_in, .line_data_plus_in, .line_data_minus_in, .card_clock_oe, .card_data_oe,
	.line_clock_plus_oe, .line_clock_minus_oe, .line_data_plus_oe, .line_data_minus_oe, .line_data_minus_o,
	.insertion_detect_output, .connected);
`default_nettype wire

// ### tb/dib_peer_model.sv
// Peer buffer and termination on one differential pair
// Assumes bridge drive outputs and a bench command to reverse the pair
`timescale 1ns/1ps
`default_nettype none
module dib_peer_model (
	input  wire logic core_clk, // Core clock
	input  wire logic term_ok,  // Terminators fitted
	input  wire logic peer_low, // Peer transmits low
	input  wire logic plus_oe,  // Bridge pulls plus low
	input  wire logic minus_oe, // Bridge drives minus
	input  wire logic minus_o,  // Bridge minus level
	output logic      plus_in,  // Plus comparator
	output logic      minus_in  // Minus comparator
);
	logic flip_reg = 1'b0;
	// Floating pair shows a changing pattern
	always_ff @(posedge core_clk) flip_reg <= ~flip_reg;
	// Bias keeps plus above minus unless a node reverses the pair
	always_comb begin
		plus_in  = term_ok ? !(plus_oe | peer_low) : flip_reg;
		minus_in = term_ok ? ((minus_oe & minus_o) | peer_low) : !flip_reg;
	end
endmodule // dib_peer_model
`default_nettype wire

// ### tb/dib_bridge_bench.sv
// Bench for the bridge: power sequence, connect, traffic, loss
// Assumes shortened timers and peer models on both pairs
`timescale 1ns/1ps
`default_nettype none
module dib_bridge_bench;
	logic clk = 0, rstn = 0, en = 0, sup_a = 0, sup_b = 0, term = 0, card_sc = 0, card_sd = 0, pk = 0, pd = 0;
	wire logic c_oe, d_oe, kp_oe, km_oe, km_o, dp_oe, dm_oe, dm_o, ido, conn, kp, km, dp, dm;
	wire logic card_k = !(c_oe | card_sc);
	wire logic card_d = !(d_oe | card_sd);
	int errors = 0, n_compared = 0;
	// Core clock
	initial forever #10 clk = ~clk;
	dib_bridge #(.SETTLE_CYC(20), .ARM_CYC(40), .IDLE_CYC(10)) DUT (.core_clk(clk), .resetn(rstn), .enable_in(en),
		.card_side_supply_ok(sup_a), .line_side_supply_ok(sup_b), .term_valid(term), .card_clock_in(card_k),
		.card_data_in(card_d), .line_clock_plus_in(kp), .line_clock_minus_in(km), .line_data_plus_in(dp),
		.line_data_minus_in(dm), .card_clock_oe(c_oe), .card_data_oe(d_oe), .line_clock_plus_oe(kp_oe),
		.line_clock_minus_oe(km_oe), .line_clock_minus_o(km_o), .line_data_plus_oe(dp_oe),
		.line_data_minus_oe(dm_oe), .line_data_minus_o(dm_o), .insertion_detect_output(ido), .connected(conn));
	dib_peer_model PK (.core_clk(clk), .term_ok(term), .peer_low(pk), .plus_oe(kp_oe), .minus_oe(km_oe),
		.minus_o(km_o), .plus_in(kp), .minus_in(km));
	dib_peer_model PD (.core_clk(clk), .term_ok(term), .peer_low(pd), .plus_oe(dp_oe), .minus_oe(dm_oe),
		.minus_o(dm_o), .plus_in(dp), .minus_in(dm));
	task automatic chk(input string nm, input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Model state: 0 apart, 1 armed, 2 joined
	task automatic st(input int m);
		chk("armed", ido, m >= 1);
		chk("connected", conn, m == 2);
	endtask
	// Peer frame on the link clock: START, random bits, STOP
	task automatic frame(input int nb);
		logic b;
		pd = 1;
		cyc(4);
		repeat (nb) begin
			b = 1'($urandom);
			pk = 1;
			pd = !b;
			cyc(4);
			chk("card clock", card_k, 1'b0);
			pk = 0;
			cyc(4);
			chk("card data", card_d, b);
		end
		pk = 1;
		pd = 1;
		cyc(4);
		pk = 0;
		cyc(4);
		pd = 0;
		cyc(5);
	endtask
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'hF03E));
		cyc(10);
		rstn = 1;
		{sup_a, sup_b, term} = 3'h7;
		cyc(50);
		st(0);
		cyc(40);
		st(1);
		$display("test power-up done");
		en = 1;
		cyc(1);
		st(1);
		cyc(17);
		st(2);
		card_sc = 1;
		card_sd = 1;
		cyc(5 + $urandom % 8);
		chk("clock plus", kp, 1'b0);
		chk("clock minus", km, 1'b1);
		chk("data plus", dp, 1'b0);
		chk("data minus", dm, 1'b1);
		card_sc = 0;
		card_sd = 0;
		cyc(6);
		chk("clock plus free", kp, 1'b1);
		chk("data plus free", dp, 1'b1);
		chk("card clock free", card_k, 1'b1);
		frame(8);
		st(2);
		// Enable changes only with both buses idle
		en = 0;
		cyc(6);
		st(1);
		en = 1;
		cyc(14);
		st(2);
		$display("test traffic done");
		for (int k = 0; k < 3; k++) begin
			{sup_a, sup_b, term} = 3'h7 ^ (3'h4 >> k);
			cyc(6);
			st(0);
			pd = 1;
			{sup_a, sup_b, term} = 3'h7;
			cyc(50);
			st(0);
			cyc(40);
			st(1);
			pd = 0;
			cyc(6);
			st(2);
			$display("test loss %0d done", k);
		end
		close_out;
	end
	// Watchdog
	initial begin
		#100000;
		errors++;
		close_out;
	end
endmodule // dib_bridge_bench
`default_nettype wire
